// ===== pkg/alarm_bank_pkg.sv
// Package: command bytes, reset values and field layout of the alarm bank
package alarm_bank_pkg;

  // ************************************************************
  // Command bytes
  // ************************************************************
  localparam logic [7:0] CMD_ALARM_A_MASK  = 8'h0c;
  localparam logic [7:0] CMD_ALARM_B_MASK  = 8'h0d;
  localparam logic [7:0] CMD_ALARM_C_MASK  = 8'h0e;
  localparam logic [7:0] CMD_LOCAL_LIMIT   = 8'h40;
  localparam logic [7:0] CMD_FAR1_LIMIT_A  = 8'h41;
  localparam logic [7:0] CMD_FAR2_LIMIT_A  = 8'h42;
  localparam logic [7:0] CMD_FAR1_LIMIT_BC = 8'h49;
  localparam logic [7:0] CMD_FAR2_LIMIT_BC = 8'h4a;
  localparam logic [7:0] CMD_HYSTERESIS    = 8'h5a;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_ALARM_A_MASK  = 8'h01;
  localparam logic [7:0] RST_ALARM_B_MASK  = 8'h00;
  localparam logic [7:0] RST_ALARM_C_MASK  = 8'h07;
  localparam logic [7:0] RST_LOCAL_LIMIT   = 8'h55;
  localparam logic [7:0] RST_FAR_LIMIT_A   = 8'h6e;
  localparam logic [7:0] RST_FAR_LIMIT_BC  = 8'h55;
  localparam logic [7:0] RST_HYSTERESIS    = 8'h0a;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int         MASK_LOCAL_BIT = 0;
  localparam int         MASK_FAR1_BIT  = 1;
  localparam int         MASK_FAR2_BIT  = 2;
  localparam logic [7:0] MASK_WR_BITS   = 8'h07;
  localparam logic [7:0] LOCAL_WR_BITS  = 8'h7f;
  localparam logic [7:0] HYST_WR_BITS   = 8'h1f;
  localparam logic [7:0] HYST_MAX       = 8'h20;

endpackage : alarm_bank_pkg

// ===== pkg/channel_cmp_if.sv
// Interface: reading, limit, hysteresis and status flag of one comparator channel
interface channel_cmp_if;
  logic [7:0] reading;
  logic [7:0] limit;
  logic [7:0] hyst;
  logic       flag;
  modport bank (output reading, output limit, output hyst, input flag);
  modport cmp  (input reading, input limit, input hyst, output flag);
endinterface : channel_cmp_if

// ===== src/hyst_compare.sv
// Hysteresis comparator producing one sticky channel status flag
module hyst_compare
  import alarm_bank_pkg::*;
(
  // Clock and reset
  input wire logic   clk,
  input wire logic   reset_n,
  // Channel
  channel_cmp_if.cmp ch
);

  logic [8:0] lowEdge;
  logic       atOrAbove;
  logic       belowLow;
  logic       flag_reg;
  logic       flag_next;

  // Nine bits so a limit under the hysteresis never wraps upward
  assign lowEdge   = {1'b0, ch.limit} - {1'b0, ch.hyst};
  assign atOrAbove = ch.reading >= ch.limit;
  assign belowLow  = lowEdge[8] ? 1'b0
                   : ({1'b0, ch.reading} < lowEdge);
  assign flag_next = atOrAbove ? 1'b1 : (belowLow ? 1'b0 : flag_reg);
  assign ch.flag   = flag_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  a_flag_sets_high: assert property (
    @(posedge clk) disable iff (!reset_n)
    ch.reading >= ch.limit |=> flag_reg)
    else $error("flag not set at or above limit");
  a_flag_holds_band: assert property (
    @(posedge clk) disable iff (!reset_n)
    (flag_reg && !belowLow) |=> flag_reg)
    else $error("flag cleared inside hysteresis band");
  a_flag_clears_low: assert property (
    @(posedge clk) disable iff (!reset_n)
    ({1'b0, ch.reading} + {1'b0, ch.hyst}) < {1'b0, ch.limit}
    |=> !flag_reg)
    else $error("flag held below the hysteresis band");

endmodule : hyst_compare

// ===== src/alarm_mask_limit_bank.sv
// Alarm mask and limit register bank with three active-low alarm outputs
// Operation
// - Mask bit 2 set blocks the remote 2 event from that alarm output.
// - Mask bit 1 set blocks the remote 1 event from that alarm output.
// - Mask bit 0 set blocks the local event from that alarm output.
// - Mask bits 7 to 3 are read-only and read as zero.
// - Each alarm output has its own mask register.
// - The local limit is an unsigned 0 to 127 degree value in bits 6:0.
// - Local limit bit 7 is read-only and reads as zero.
// - The local limit decides when the local error event is raised.
// - Each remote limit is a full unsigned 8-bit 0 to 255 degree value.
// - The first remote limit pair feeds only the first alarm output.
// - The second remote limit pair is shared by alarm outputs two and three.
// - A flag sets at or above its limit and clears below limit minus hyst.
// - An alarm is active while any unmasked flag is set.
// - A 0 to 31 degree hysteresis at command 0x5a lowers the clear point of every limit.
module alarm_mask_limit_bank
  import alarm_bank_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Register access by command byte
  input  wire logic [7:0] cmdByte,
  input  wire logic       wrStrobe,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData,
  // Temperature readings, whole degrees
  input  wire logic [7:0] localTemp,
  input  wire logic [7:0] far1Temp,
  input  wire logic [7:0] far2Temp,
  // Alarm outputs, active low
  output logic            alarm_out_a_n,
  output logic            alarm_out_b_n,
  output logic            alarm_out_c_n
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] maskA_reg, maskB_reg, maskC_reg;
  logic [7:0] localLimit_reg, far1LimA_reg, far2LimA_reg;
  logic [7:0] far1LimBC_reg, far2LimBC_reg, hyst_reg;
  logic [7:0] hystClamped;
  logic [7:0] rdData_next;

  function automatic logic [7:0] keepBits(input logic [7:0] d,
                                          input logic [7:0] m);
    keepBits = d & m;
  endfunction : keepBits

  // Writes keep bits 4:0 only, so the clamp to 32 never takes effect
  assign hystClamped = (wrData & HYST_WR_BITS) > HYST_MAX ? HYST_MAX
                     : keepBits(wrData, HYST_WR_BITS);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      maskA_reg      <= RST_ALARM_A_MASK;
      maskB_reg      <= RST_ALARM_B_MASK;
      maskC_reg      <= RST_ALARM_C_MASK;
      localLimit_reg <= RST_LOCAL_LIMIT;
      far1LimA_reg   <= RST_FAR_LIMIT_A;
      far2LimA_reg   <= RST_FAR_LIMIT_A;
      far1LimBC_reg  <= RST_FAR_LIMIT_BC;
      far2LimBC_reg  <= RST_FAR_LIMIT_BC;
      hyst_reg       <= RST_HYSTERESIS;
    end else if (wrStrobe) begin
      unique case (cmdByte)
        CMD_ALARM_A_MASK:  maskA_reg <= keepBits(wrData, MASK_WR_BITS);
        CMD_ALARM_B_MASK:  maskB_reg <= keepBits(wrData, MASK_WR_BITS);
        CMD_ALARM_C_MASK:  maskC_reg <= keepBits(wrData, MASK_WR_BITS);
        CMD_LOCAL_LIMIT:
          localLimit_reg <= keepBits(wrData, LOCAL_WR_BITS);
        CMD_FAR1_LIMIT_A:  far1LimA_reg  <= wrData;
        CMD_FAR2_LIMIT_A:  far2LimA_reg  <= wrData;
        CMD_FAR1_LIMIT_BC: far1LimBC_reg <= wrData;
        CMD_FAR2_LIMIT_BC: far2LimBC_reg <= wrData;
        CMD_HYSTERESIS:    hyst_reg      <= hystClamped;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Read-back, registered; unmapped bytes read zero
  // ************************************************************
  assign rdData_next =
      (cmdByte == CMD_ALARM_A_MASK)  ? maskA_reg      :
      (cmdByte == CMD_ALARM_B_MASK)  ? maskB_reg      :
      (cmdByte == CMD_ALARM_C_MASK)  ? maskC_reg      :
      (cmdByte == CMD_LOCAL_LIMIT)   ? localLimit_reg :
      (cmdByte == CMD_FAR1_LIMIT_A)  ? far1LimA_reg   :
      (cmdByte == CMD_FAR2_LIMIT_A)  ? far2LimA_reg   :
      (cmdByte == CMD_FAR1_LIMIT_BC) ? far1LimBC_reg  :
      (cmdByte == CMD_FAR2_LIMIT_BC) ? far2LimBC_reg  :
      (cmdByte == CMD_HYSTERESIS)    ? hyst_reg       : 8'h00;

  // ************************************************************
  // Comparators: local shared, remotes split by limit pair
  // ************************************************************
  channel_cmp_if chLocal ();
  channel_cmp_if chF1A ();
  channel_cmp_if chF2A ();
  channel_cmp_if chF1BC ();
  channel_cmp_if chF2BC ();

  assign chLocal.reading = localTemp;
  assign chLocal.limit   = localLimit_reg;
  assign chLocal.hyst    = hyst_reg;
  assign chF1A.reading   = far1Temp;
  assign chF1A.limit     = far1LimA_reg;
  assign chF1A.hyst      = hyst_reg;
  assign chF2A.reading   = far2Temp;
  assign chF2A.limit     = far2LimA_reg;
  assign chF2A.hyst      = hyst_reg;
  assign chF1BC.reading  = far1Temp;
  assign chF1BC.limit    = far1LimBC_reg;
  assign chF1BC.hyst     = hyst_reg;
  assign chF2BC.reading  = far2Temp;
  assign chF2BC.limit    = far2LimBC_reg;
  assign chF2BC.hyst     = hyst_reg;

  hyst_compare uCmpLocal (.clk(clk), .reset_n(reset_n), .ch(chLocal));
  hyst_compare uCmpF1A   (.clk(clk), .reset_n(reset_n), .ch(chF1A));
  hyst_compare uCmpF2A   (.clk(clk), .reset_n(reset_n), .ch(chF2A));
  hyst_compare uCmpF1BC  (.clk(clk), .reset_n(reset_n), .ch(chF1BC));
  hyst_compare uCmpF2BC  (.clk(clk), .reset_n(reset_n), .ch(chF2BC));

  // ************************************************************
  // Mask gating
  // ************************************************************
  logic [2:0] flagsA, flagsBC;
  logic       alarmA, alarmB, alarmC;

  function automatic logic gateAlarm(input logic [2:0] flags,
                                     input logic [7:0] mask);
    gateAlarm = (flags[MASK_LOCAL_BIT] & ~mask[MASK_LOCAL_BIT])
              | (flags[MASK_FAR1_BIT]  & ~mask[MASK_FAR1_BIT])
              | (flags[MASK_FAR2_BIT]  & ~mask[MASK_FAR2_BIT]);
  endfunction : gateAlarm

  assign flagsA  = {chF2A.flag, chF1A.flag, chLocal.flag};
  assign flagsBC = {chF2BC.flag, chF1BC.flag, chLocal.flag};
  assign alarmA  = gateAlarm(flagsA, maskA_reg);
  assign alarmB  = gateAlarm(flagsBC, maskB_reg);
  assign alarmC  = gateAlarm(flagsBC, maskC_reg);

  // Outputs registered so pins never glitch on mask writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData        <= 8'h00;
      alarm_out_a_n <= 1'b1;
      alarm_out_b_n <= 1'b1;
      alarm_out_c_n <= 1'b1;
    end else begin
      rdData        <= rdData_next;
      alarm_out_a_n <= ~alarmA;
      alarm_out_b_n <= ~alarmB;
      alarm_out_c_n <= ~alarmC;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_mask_reserved_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    (maskA_reg[7:3] == 5'h00) && (maskB_reg[7:3] == 5'h00)
    && (maskC_reg[7:3] == 5'h00))
    else $error("mask reserved bits not zero");
  a_local_bit7_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    wrStrobe && cmdByte == CMD_LOCAL_LIMIT |=> !localLimit_reg[7]
    && localLimit_reg[6:0] == $past(wrData[6:0]))
    else $error("local limit write wrong");
  a_far_limit_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    wrStrobe && cmdByte == CMD_FAR1_LIMIT_BC |=>
    far1LimBC_reg == $past(wrData))
    else $error("remote limit not fully written");
  a_far2_mask_block: assert property (
    @(posedge clk) disable iff (!reset_n)
    maskA_reg[MASK_FAR2_BIT] && !chF1A.flag && !chLocal.flag
    |=> alarm_out_a_n)
    else $error("masked remote 2 reached alarm a");
  a_far1_pass: assert property (
    @(posedge clk) disable iff (!reset_n)
    !maskB_reg[MASK_FAR1_BIT] && chF1BC.flag |=> !alarm_out_b_n)
    else $error("unmasked remote 1 missed alarm b");
  a_local_pass: assert property (
    @(posedge clk) disable iff (!reset_n)
    !maskC_reg[MASK_LOCAL_BIT] && chLocal.flag |=> !alarm_out_c_n)
    else $error("unmasked local missed alarm c");
  a_far2_bc_pass: assert property (
    @(posedge clk) disable iff (!reset_n)
    !maskC_reg[MASK_FAR2_BIT] && chF2BC.flag |=> !alarm_out_c_n)
    else $error("unmasked remote 2 missed alarm c");
  a_alarm_a_own: assert property (
    @(posedge clk) disable iff (!reset_n)
    !chF1A.flag && !chF2A.flag
    && (maskA_reg[MASK_LOCAL_BIT] || !chLocal.flag) |=> alarm_out_a_n)
    else $error("shared limit pair reached alarm a");
  a_alarm_clears: assert property (
    @(posedge clk) disable iff (!reset_n)
    flagsBC == 3'b000 |=> alarm_out_b_n && alarm_out_c_n)
    else $error("alarm active with no flags");
  a_hyst_range: assert property (
    @(posedge clk) disable iff (!reset_n)
    hyst_reg <= HYST_MAX)
    else $error("hysteresis out of range");
  a_readback_mask: assert property (
    @(posedge clk) disable iff (!reset_n)
    cmdByte == CMD_ALARM_A_MASK && !wrStrobe |=> rdData == $past(maskA_reg))
    else $error("mask read-back wrong");

  c_alarm_a: cover property (@(posedge clk) disable iff (!reset_n)
    !alarm_out_a_n);
  c_alarm_b_c: cover property (@(posedge clk) disable iff (!reset_n)
    !alarm_out_b_n && alarm_out_c_n);
  c_alarm_release: cover property (@(posedge clk) disable iff (!reset_n)
    !alarm_out_a_n ##1 alarm_out_a_n);
  c_all_alarms: cover property (@(posedge clk) disable iff (!reset_n)
    !alarm_out_a_n && !alarm_out_b_n && !alarm_out_c_n);

endmodule : alarm_mask_limit_bank

// ===== test/reg_host_model.sv
// Host model issuing command byte writes and reads to the alarm bank
module reg_host_model (
  // Clock
  input  wire logic       clk,
  // Register access
  output logic      [7:0] cmdByte,
  output logic            wrStrobe,
  output logic      [7:0] wrData,
  input  wire logic [7:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmdByte  = 8'h00;
    wrStrobe = 1'b0;
    wrData   = 8'h00;
  end

  // Data inverted once released, so a stale byte never looks valid
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] val);
    @(posedge clk);
    cmdByte  <= addr;
    wrData   <= val;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    wrData   <= ~val;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] val);
    @(posedge clk);
    cmdByte <= addr;
    @(posedge clk);
    #1;
    val = rdData;
  endtask : read_reg
endmodule : reg_host_model

// ===== test/test_alarm_mask_limit_bank.sv
// Self-checking bench for the alarm mask and limit bank
module test_alarm_mask_limit_bank
  import alarm_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] cmdByte, wrData, rdData;
  logic       wrStrobe, alarmA, alarmB, alarmC;
  logic [7:0] tempIn [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] regCmd [8] = '{CMD_ALARM_A_MASK, CMD_ALARM_B_MASK,
    CMD_ALARM_C_MASK, CMD_LOCAL_LIMIT, CMD_FAR1_LIMIT_A, CMD_FAR2_LIMIT_A,
    CMD_FAR1_LIMIT_BC, CMD_FAR2_LIMIT_BC};
  logic [7:0] rstVal [8] = '{8'h01, 8'h00, 8'h07, 8'h55, 8'h6e, 8'h6e,
    8'h55, 8'h55};
  logic [7:0] fullVal [8] = '{8'h07, 8'h07, 8'h07, 8'h7f, 8'hff, 8'hff,
    8'hff, 8'hff};
  logic [7:0] cmdA [3] = '{CMD_LOCAL_LIMIT, CMD_FAR1_LIMIT_A,
    CMD_FAR2_LIMIT_A};
  logic [7:0] cmdBc [3] = '{CMD_LOCAL_LIMIT, CMD_FAR1_LIMIT_BC,
    CMD_FAR2_LIMIT_BC};
  logic [7:0] limA [3] = '{8'h40, 8'h50, 8'h60};
  logic [7:0] limBc [3] = '{8'h40, 8'h70, 8'h80};
  int         errCount = 0;
  int         comparisons = 0;

  always #5 clk = ~clk;

  alarm_mask_limit_bank alarm_mask_limit_bank_i (
    .clk(clk), .reset_n(reset_n), .cmdByte(cmdByte), .wrStrobe(wrStrobe),
    .wrData(wrData), .rdData(rdData), .localTemp(tempIn[0]),
    .far1Temp(tempIn[1]), .far2Temp(tempIn[2]), .alarm_out_a_n(alarmA),
    .alarm_out_b_n(alarmB), .alarm_out_c_n(alarmC));

  reg_host_model reg_host_model_i (
    .clk(clk), .cmdByte(cmdByte), .wrStrobe(wrStrobe), .wrData(wrData),
    .rdData(rdData));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] val;
    reg_host_model_i.read_reg(addr, val);
    check(val, exp);
  endtask : rd_chk

  // Pin follows a reading two edges later; a third edge gives margin
  task automatic alarm_chk(input logic [2:0] exp);
    repeat (3) @(posedge clk);
    #1;
    check({5'h00, alarmA, alarmB, alarmC}, {5'h00, exp});
  endtask : alarm_chk

  task automatic set_temp(input int c, input logic [7:0] v);
    @(posedge clk);
    tempIn[c] <= v;
  endtask : set_temp

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  initial begin
    #100us;
    errCount++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(regCmd[i], rstVal[i]);
    rd_chk(CMD_HYSTERESIS, 8'h0a);
    alarm_chk(3'b111);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) reg_host_model_i.write_reg(regCmd[i], 8'hff);
    reg_host_model_i.write_reg(CMD_HYSTERESIS, 8'hff);
    for (int i = 0; i < 8; i++) begin
      rd_chk(regCmd[i], fullVal[i]);
    end
    rd_chk(CMD_HYSTERESIS, 8'h1f);
    reg_host_model_i.write_reg(8'h10, 8'h20);
    rd_chk(8'h10, 8'h00);
    $display("test access kinds done");
    // Mid-run reset must bring every written register back
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(regCmd[i], rstVal[i]);
    rd_chk(CMD_HYSTERESIS, 8'h0a);
    alarm_chk(3'b111);
    $display("test mid-run reset done");
    for (int i = 0; i < 3; i++) reg_host_model_i.write_reg(regCmd[i], 8'h00);
    for (int c = 0; c < 3; c++) begin
      reg_host_model_i.write_reg(cmdA[c], limA[c]);
      reg_host_model_i.write_reg(cmdBc[c], limBc[c]);
    end
    for (int c = 0; c < 3; c++) begin
      set_temp(c, limA[c] - 8'd1);
      alarm_chk(3'b111);
      set_temp(c, limA[c]);
      alarm_chk(c == 0 ? 3'b000 : 3'b011);
      set_temp(c, limBc[c]);
      alarm_chk(3'b000);
      reg_host_model_i.write_reg(CMD_ALARM_A_MASK, 8'h01 << c);
      alarm_chk(3'b100);
      reg_host_model_i.write_reg(CMD_ALARM_C_MASK, 8'h01 << c);
      alarm_chk(3'b101);
      reg_host_model_i.write_reg(CMD_ALARM_B_MASK, 8'h01 << c);
      alarm_chk(3'b111);
      for (int i = 0; i < 3; i++) reg_host_model_i.write_reg(regCmd[i], 8'h00);
      set_temp(c, limBc[c] - 8'd10);
      alarm_chk(3'b000);
      set_temp(c, limBc[c] - 8'd11);
      alarm_chk(c == 0 ? 3'b111 : 3'b011);
      set_temp(c, 8'h00);
      alarm_chk(3'b111);
    end
    $display("test alarm path done");
    end_sim();
  end
endmodule : test_alarm_mask_limit_bank
